// >>> bench/microcore_wait_spiwr_xor_tb.sv
// Purpose: self-checking bench for the wait / spi write / xor execution block
// Assumes: registered outputs, checks made at the falling edge once updates have settled
// Notes:   xor and wait cases are table rows; endless wait, reset and spi are hand-written
`default_nettype none

module microcore_wait_spiwr_xor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk, nrst, ivalid, row_wr, imm_ld, alu_ld, sa_ld, sd_ld;  // clock, reset, strobes
  logic [1:0]  iop, ld_sel, rd_sel;                                      // code, register selects
  logic [4:0]  iarg;                                                     // row select / operand
  logic [2:0]  ridx, rcond;                                              // wait row setup
  logic [9:0]  rdest, sa_in, pc, sp_addr, pc_hold;                       // addresses
  logic [7:0]  cond;                                                     // live conditions
  logic [15:0] imm_in, ld_data, sd_in, sp_data, rd_data;                 // data paths
  logic        waiting, busy, stb, fail, mz, mo;                         // status outputs
  int          miscompares, compares;                                    // verdict counters
  typedef struct packed {logic [1:0] sel; logic [15:0] init, imm, res; logic z, o;} xrow_t;
  typedef struct packed {logic [4:0] arg; logic [7:0] decoy, hit; logic [9:0] dest;} wrow_t;
  // xor rows: a none-row after each all-ones row proves the flags clear again
  xrow_t xrows [6] = '{'{2'h0, 16'h1234, 16'h1234, 16'h0000, 1'b1, 1'b0},
                       '{2'h1, 16'h00ff, 16'hff00, 16'hffff, 1'b0, 1'b1},
                       '{2'h2, 16'ha5a5, 16'h0f0f, 16'haaaa, 1'b0, 1'b0},
                       '{2'h3, 16'hffff, 16'hffff, 16'h0000, 1'b1, 1'b0},
                       '{2'h3, 16'h7fff, 16'h8000, 16'hffff, 1'b0, 1'b1},
                       '{2'h0, 16'h8000, 16'h8001, 16'h0001, 1'b0, 1'b0}};
  // wait rows: decoy fires only rows left disabled, hit names the winner
  wrow_t wrows [5] = '{'{5'h01, 8'h1e, 8'h01, 10'h040},
                       '{5'h10, 8'h0f, 8'h10, 10'h044},
                       '{5'h06, 8'h19, 8'h06, 10'h041},
                       '{5'h1f, 8'he0, 8'h14, 10'h042},
                       '{5'h0a, 8'h15, 8'h08, 10'h043}};

  microcore_exec i_microcore_exec (
    .CLK(clk), .NRST(nrst), .INSTR_VALID(ivalid), .INSTR_OP(iop), .INSTR_ARG(iarg),
    .ROW_WR(row_wr), .ROW_IDX(ridx), .ROW_COND(rcond), .ROW_DEST(rdest), .COND(cond),
    .IMM_LD(imm_ld), .IMM_IN(imm_in), .ALU_LD(alu_ld), .ALU_LD_SEL(ld_sel),
    .ALU_LD_DATA(ld_data), .ALU_RD_SEL(rd_sel), .SPI_ADDR_LD(sa_ld), .SPI_ADDR_IN(sa_in),
    .SPI_DATA_LD(sd_ld), .SPI_DATA_IN(sd_in), .PC(pc), .WAITING(waiting), .SPI_BUSY(busy),
    .SPI_WR_STB(stb), .SPI_WR_ADDR(sp_addr), .SPI_WR_DATA(sp_data), .SPI_WR_FAIL(fail),
    .MASK_ZERO(mz), .MASK_ONES(mo), .ALU_RD_DATA(rd_data));

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // case-equality compare so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // load operand and mask, issue xor, then look at flags, pc and the register
  task automatic do_xor(input xrow_t r);
    logic [9:0] pc0;
    @(posedge clk); alu_ld <= 1'b1; ld_sel <= r.sel; ld_data <= r.init; rd_sel <= r.sel;
    imm_ld <= 1'b1; imm_in <= r.imm;
    @(posedge clk); alu_ld <= 1'b0; imm_ld <= 1'b0; ivalid <= 1'b1;
    iop <= mc_pkg::OP_XOR; iarg <= 5'(r.sel);
    @(negedge clk); pc0 = pc;
    @(posedge clk); ivalid <= 1'b0;
    @(negedge clk);
    chk(16'(mz), 16'(r.z));
    chk(16'(mo), 16'(r.o));
    chk(16'(pc), 16'(pc0 + mc_pkg::PC_STEP));
    @(negedge clk); chk(rd_data, r.res);
  endtask

  // wait on the selected rows; a decoy and an ignored instruction must not end it
  task automatic do_wait(input wrow_t r);
    logic [9:0] pc0;
    @(negedge clk); pc0 = pc;
    @(posedge clk); ivalid <= 1'b1; iop <= mc_pkg::OP_WAIT; iarg <= r.arg; cond <= 8'h00;
    @(posedge clk); iop <= mc_pkg::OP_NOP; cond <= r.decoy;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(16'(waiting), 16'h0001);
    chk(16'(pc), 16'(pc0));
    @(posedge clk); ivalid <= 1'b0; cond <= r.hit;
    @(posedge clk); cond <= 8'h00;
    @(negedge clk);
    chk(16'(pc), 16'(r.dest));
    chk(16'(waiting), 16'h0000);
  endtask

  // backdoor write, optionally disturbed by loads in the cycle after issue
  task automatic do_spi(input logic [9:0] a, input logic [15:0] d, input logic cha,
                        input logic chd, input logic [9:0] na, input logic [15:0] nd);
    logic [9:0]  ea;
    logic [15:0] ed;
    ea = cha ? na : a;
    // only a value load disturbs the data; an address-only load keeps the sampled value
    ed = chd ? (nd ^ d) : d;
    @(posedge clk); sa_ld <= 1'b1; sa_in <= a; sd_ld <= 1'b1; sd_in <= d;
    @(posedge clk); sa_ld <= 1'b0; sd_ld <= 1'b0; ivalid <= 1'b1; iop <= mc_pkg::OP_WRSPI;
    @(posedge clk); ivalid <= 1'b0; sa_ld <= cha; sa_in <= na; sd_ld <= chd; sd_in <= nd;
    @(negedge clk);
    chk(16'(busy), 16'h0001);
    chk(16'(stb), 16'h0000);
    @(posedge clk); sa_ld <= 1'b0; sd_ld <= 1'b0;
    @(negedge clk);
    chk(16'(stb), 16'h0001);
    chk(16'(sp_addr), 16'(ea));
    chk(sp_data, ed);
    chk(16'(fail), 16'(cha | chd));
    @(negedge clk); chk(16'(stb), 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, ivalid, row_wr, imm_ld, alu_ld, sa_ld, sd_ld} = '0;
    {iop, ld_sel, rd_sel, iarg, ridx, rcond, rdest, sa_in, cond} = '0;
    {imm_in, ld_data, sd_in} = '0;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk(16'(pc), 16'(mc_pkg::PC_RESET));
    chk(16'({waiting, busy, stb, fail, mz, mo}), 16'h0000);
    // row n watches condition line n-1 and jumps to 0x040 + n-1
    for (int i = 0; i < mc_pkg::WAIT_ROWS; i++) begin
      @(posedge clk); row_wr <= 1'b1; ridx <= 3'(i); rcond <= 3'(i); rdest <= 10'h040 + 10'(i);
    end
    @(posedge clk); row_wr <= 1'b0;
    foreach (xrows[i]) do_xor(xrows[i]);
    foreach (wrows[i]) do_wait(wrows[i]);
    do_spi(10'h155, 16'hc3a5, 1'b0, 1'b0, 10'h000, 16'h0000);
    do_spi(10'h2aa, 16'h1234, 1'b0, 1'b1, 10'h000, 16'hff00);
    do_spi(10'h0f0, 16'h5a5a, 1'b1, 1'b0, 10'h3ff, 16'h0000);
    // empty select: every condition true yet the core stays put until reset
    @(posedge clk); ivalid <= 1'b1; iop <= mc_pkg::OP_WAIT; iarg <= mc_pkg::WAIT_NONE;
    @(posedge clk); ivalid <= 1'b0; cond <= 8'hff;
    @(negedge clk); pc_hold = pc;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(16'(waiting), 16'h0001);
    chk(16'(pc), 16'(pc_hold));
    @(posedge clk); nrst <= 1'b0;
    @(negedge clk);
    chk(16'({waiting, mz, mo, stb}), 16'h0000);
    chk(16'(pc), 16'(mc_pkg::PC_RESET));
    repeat (3) @(posedge clk);
    nrst <= 1'b1; cond <= 8'h00;
    repeat (2) @(posedge clk);
    test_done;
  end

  // hang guard: a run past this bound is a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule

`default_nettype wire

// >>> hw/mc_pkg.sv
// Purpose: shared constants for the microcore wait / spi write / xor execution block
// Assumes: one core clock, asynchronous active-low reset
// Notes:   opcode codes on the instruction port are local choices of this block
`default_nettype none

package mc_pkg;
  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int WAIT_ROWS  = 5;   // rows in the wait table
  localparam int ROW_IDX_W  = 3;   // row index width (rows 0..4 internally)
  localparam int PC_W       = 10;  // program counter width
  localparam int DATA_W     = 16;  // alu data width
  localparam int ALU_REGS   = 4;   // registers in the alu operand set
  localparam int ALU_SEL_W  = 2;   // first operand field width
  localparam int COND_N     = 8;   // wait conditions offered to the table
  localparam int COND_SEL_W = 3;   // condition selector width per row
  localparam int SPI_ADDR_W = 10;  // backdoor address width

  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [WAIT_ROWS-1:0] WAIT_NONE     = 5'h00;      // no row enabled
  localparam logic [DATA_W-1:0]    MASK_ALL_ZERO = 16'h0000;   // all-zero result
  localparam logic [DATA_W-1:0]    MASK_ALL_ONES = 16'hffff;   // all-ones result
  localparam logic [PC_W-1:0]      PC_RESET      = 10'h000;    // pc after reset
  localparam logic [PC_W-1:0]      PC_STEP       = 10'h001;    // pc increment

  // ----------------------------------------------------------------
  // instruction codes on the instruction port
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_NOP   = 2'h0;  // anything else, just advance
  localparam logic [1:0] OP_WAIT  = 2'h1;  // wait on selected rows
  localparam logic [1:0] OP_WRSPI = 2'h2;  // backdoor write request
  localparam logic [1:0] OP_XOR   = 2'h3;  // xor operand with immediate mask

  // core sequencing
  typedef enum logic {ST_RUN, ST_WAIT} core_state_t;
endpackage

`default_nettype wire

// >>> hw/microcore_exec.sv
// Purpose: execution of wait, spi backdoor write request and xor-mask instructions
// Assumes: one instruction offered per cycle at PC; loads stand in for other instructions
// Notes:   all outputs are registered; instructions are ignored while waiting
`default_nettype none

module microcore_exec (
  input  wire logic                          CLK,          // core clock, 25 MHz
  input  wire logic                          NRST,         // async reset, low
  input  wire logic                          INSTR_VALID,  // instruction offered
  input  wire logic [1:0]                    INSTR_OP,     // instruction code
  input  wire logic [mc_pkg::WAIT_ROWS-1:0]  INSTR_ARG,    // row select / operand
  input  wire logic                          ROW_WR,       // wait row setup strobe
  input  wire logic [mc_pkg::ROW_IDX_W-1:0]  ROW_IDX,      // row 0..4
  input  wire logic [mc_pkg::COND_SEL_W-1:0] ROW_COND,     // row condition select
  input  wire logic [mc_pkg::PC_W-1:0]       ROW_DEST,     // row destination
  input  wire logic [mc_pkg::COND_N-1:0]     COND,         // live wait conditions
  input  wire logic                          IMM_LD,       // load immediate mask
  input  wire logic [mc_pkg::DATA_W-1:0]     IMM_IN,       // immediate mask value
  input  wire logic                          ALU_LD,       // load an alu register
  input  wire logic [mc_pkg::ALU_SEL_W-1:0]  ALU_LD_SEL,   // which alu register
  input  wire logic [mc_pkg::DATA_W-1:0]     ALU_LD_DATA,  // value to load
  input  wire logic [mc_pkg::ALU_SEL_W-1:0]  ALU_RD_SEL,   // register to observe
  input  wire logic                          SPI_ADDR_LD,  // load target address
  input  wire logic [mc_pkg::SPI_ADDR_W-1:0] SPI_ADDR_IN,  // target address value
  input  wire logic                          SPI_DATA_LD,  // load write value
  input  wire logic [mc_pkg::DATA_W-1:0]     SPI_DATA_IN,  // write value
  output logic [mc_pkg::PC_W-1:0]            PC,           // program counter
  output logic                               WAITING,      // stalled in wait
  output logic                               SPI_BUSY,     // write in first cycle
  output logic                               SPI_WR_STB,   // write completes
  output logic [mc_pkg::SPI_ADDR_W-1:0]      SPI_WR_ADDR,  // write address
  output logic [mc_pkg::DATA_W-1:0]          SPI_WR_DATA,  // write data
  output logic                               SPI_WR_FAIL,  // write was corrupted
  output logic                               MASK_ZERO,    // all-zero flag
  output logic                               MASK_ONES,    // all-ones flag
  output logic [mc_pkg::DATA_W-1:0]          ALU_RD_DATA   // observed alu register
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mc_pkg::core_state_t          state;           // run or wait
  logic [mc_pkg::WAIT_ROWS-1:0] wait_row_select; // latched row select
  logic [mc_pkg::DATA_W-1:0]    alu_operand_set [mc_pkg::ALU_REGS]; // operand regs
  logic [mc_pkg::DATA_W-1:0]    alu_immediate_mask_reg;             // xor mask
  logic [mc_pkg::SPI_ADDR_W-1:0] spi_addr;       // target-address register
  logic [mc_pkg::DATA_W-1:0]    spi_data;        // write-value register
  logic [mc_pkg::SPI_ADDR_W-1:0] cap_addr;       // address sampled at issue
  logic [mc_pkg::DATA_W-1:0]    cap_data;        // data sampled at issue
  logic                         wt_hit;          // wait table satisfied
  logic [mc_pkg::PC_W-1:0]      wt_dest;         // destination of winner

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                         accept;          // instruction taken this cycle
  logic                         do_wait;         // wait issued
  logic                         do_spi;          // write request issued
  logic                         do_xor;          // xor issued
  logic [mc_pkg::ALU_SEL_W-1:0] first_operand_field; // xor operand select
  logic [mc_pkg::DATA_W-1:0]    xor_result;      // result of the xor

  // decoding is used for three opcodes, so keep it in one place
  function automatic logic is_op(input logic [1:0] op, input logic [1:0] code);
    return op == code;
  endfunction

  assign accept              = INSTR_VALID && (state == mc_pkg::ST_RUN);
  assign do_wait             = accept && is_op(INSTR_OP, mc_pkg::OP_WAIT);
  assign do_spi              = accept && is_op(INSTR_OP, mc_pkg::OP_WRSPI);
  assign do_xor              = accept && is_op(INSTR_OP, mc_pkg::OP_XOR);
  assign first_operand_field = INSTR_ARG[mc_pkg::ALU_SEL_W-1:0];
  assign xor_result = alu_operand_set[first_operand_field] ^ alu_immediate_mask_reg;

  // ----------------------------------------------------------------
  // wait table
  // ----------------------------------------------------------------
  wait_table i_wait_table (
    .clk        (CLK),
    .nrst       (NRST),
    .row_wr     (ROW_WR),
    .row_idx    (ROW_IDX),
    .row_cond   (ROW_COND),
    .row_dest   (ROW_DEST),
    .cond       (COND),
    .row_select (wait_row_select),
    .hit        (wt_hit),
    .hit_dest   (wt_dest)
  );

  // ----------------------------------------------------------------
  // sequencing and program counter
  // ----------------------------------------------------------------
  // a wait always parks for at least one cycle; an all-zero select never hits
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state           <= mc_pkg::ST_RUN;
      wait_row_select <= mc_pkg::WAIT_NONE;
      PC              <= mc_pkg::PC_RESET;
      WAITING         <= 1'b0;
    end else begin
      case (state)
        mc_pkg::ST_RUN: begin
          if (do_wait) begin
            state           <= mc_pkg::ST_WAIT;
            wait_row_select <= INSTR_ARG;
            WAITING         <= 1'b1;
          end else if (accept) begin
            PC <= PC + mc_pkg::PC_STEP;
          end
        end
        mc_pkg::ST_WAIT: begin
          if (wt_hit) begin
            PC              <= wt_dest;
            state           <= mc_pkg::ST_RUN;
            WAITING         <= 1'b0;
            wait_row_select <= mc_pkg::WAIT_NONE;
          end
        end
        default: begin
          state   <= mc_pkg::ST_RUN;
          WAITING <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alu registers, immediate mask and flags
  // ----------------------------------------------------------------
  // xor overrides any same-cycle load, even of another register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < mc_pkg::ALU_REGS; i++) begin
        alu_operand_set[i] <= '0;
      end
    end else if (do_xor) begin
      alu_operand_set[first_operand_field] <= xor_result;
    end else if (ALU_LD) begin
      alu_operand_set[ALU_LD_SEL] <= ALU_LD_DATA;
    end
  end

  // immediate mask loaded by other instructions
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      alu_immediate_mask_reg <= '0;
    end else if (IMM_LD) begin
      alu_immediate_mask_reg <= IMM_IN;
    end
  end

  // flags are rewritten by every xor, so a miss clears them
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MASK_ZERO <= 1'b0;
      MASK_ONES <= 1'b0;
    end else if (do_xor) begin
      MASK_ZERO <= (xor_result == mc_pkg::MASK_ALL_ZERO);
      MASK_ONES <= (xor_result == mc_pkg::MASK_ALL_ONES);
    end
  end

  // observation copy of one alu register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ALU_RD_DATA <= '0;
    end else begin
      ALU_RD_DATA <= alu_operand_set[ALU_RD_SEL];
    end
  end

  // ----------------------------------------------------------------
  // spi backdoor write
  // ----------------------------------------------------------------
  // address and value registers, loaded by earlier instructions
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      spi_addr <= '0;
      spi_data <= '0;
    end else begin
      if (SPI_ADDR_LD) begin
        spi_addr <= SPI_ADDR_IN;
      end
      if (SPI_DATA_LD) begin
        spi_data <= SPI_DATA_IN;
      end
    end
  end

  // cycle one samples the registers; cycle two completes the write.
  // a load during cycle two is the following instruction touching them,
  // and the write then carries the disturbed value and is flagged.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SPI_BUSY    <= 1'b0;
      SPI_WR_STB  <= 1'b0;
      SPI_WR_ADDR <= '0;
      SPI_WR_DATA <= '0;
      SPI_WR_FAIL <= 1'b0;
      cap_addr    <= '0;
      cap_data    <= '0;
    end else begin
      SPI_BUSY   <= do_spi;
      SPI_WR_STB <= SPI_BUSY;
      if (do_spi) begin
        cap_addr <= spi_addr;
        cap_data <= spi_data;
      end
      if (SPI_BUSY) begin
        SPI_WR_FAIL <= SPI_ADDR_LD || SPI_DATA_LD;
        SPI_WR_ADDR <= SPI_ADDR_LD ? SPI_ADDR_IN : cap_addr;
        SPI_WR_DATA <= SPI_DATA_LD ? (SPI_DATA_IN ^ cap_data) : cap_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_wait_none_stalls: assert property (@(posedge CLK) disable iff (!NRST)
    (WAITING && wait_row_select == mc_pkg::WAIT_NONE) |=> WAITING && $stable(PC))
    else $error("empty row select left the wait");

  a_wait_pc_hold: assert property (@(posedge CLK) disable iff (!NRST)
    (state == mc_pkg::ST_WAIT && !wt_hit) |=> $stable(PC) && WAITING)
    else $error("pc moved during wait");

  a_wait_jump_dest: assert property (@(posedge CLK) disable iff (!NRST)
    (state == mc_pkg::ST_WAIT && wt_hit) |=> PC == $past(wt_dest) && !WAITING)
    else $error("wait did not jump to row destination");

  a_spi_two_cycles: assert property (@(posedge CLK) disable iff (!NRST)
    do_spi |=> SPI_BUSY ##1 SPI_WR_STB)
    else $error("spi write not complete after two cycles");

  a_spi_addr_src: assert property (@(posedge CLK) disable iff (!NRST)
    (do_spi ##1 !SPI_ADDR_LD) |=> SPI_WR_ADDR == $past(spi_addr, 2))
    else $error("spi write address not from address register");

  a_spi_data_src: assert property (@(posedge CLK) disable iff (!NRST)
    (do_spi ##1 (!SPI_DATA_LD && !SPI_ADDR_LD)) |=> SPI_WR_DATA == $past(spi_data, 2)
      && !SPI_WR_FAIL)
    else $error("spi write data not from value register");

  a_spi_change_fail: assert property (@(posedge CLK) disable iff (!NRST)
    (do_spi ##1 (SPI_ADDR_LD || SPI_DATA_LD)) |=> SPI_WR_FAIL && SPI_WR_STB)
    else $error("register change after request not flagged");

  a_xor_result: assert property (@(posedge CLK) disable iff (!NRST)
    do_xor |=> alu_operand_set[$past(first_operand_field)] == $past(xor_result))
    else $error("xor result not written to operand");

  a_flag_zero: assert property (@(posedge CLK) disable iff (!NRST)
    do_xor |=> MASK_ZERO == ($past(xor_result) == mc_pkg::MASK_ALL_ZERO))
    else $error("all-zero flag wrong after xor");

  a_flag_ones: assert property (@(posedge CLK) disable iff (!NRST)
    do_xor |=> MASK_ONES == ($past(xor_result) == mc_pkg::MASK_ALL_ONES))
    else $error("all-ones flag wrong after xor");
endmodule

`default_nettype wire

// >>> hw/wait_table.sv
// Purpose: five-row wait table, each row a condition selector and a destination
// Assumes: rows are written by the wait-row setup instructions through row_wr
// Notes:   lowest enabled satisfied row wins when several fire together
`default_nettype none

module wait_table (
  input  wire logic                          clk,        // core clock
  input  wire logic                          nrst,       // async reset, low
  input  wire logic                          row_wr,     // write one row
  input  wire logic [mc_pkg::ROW_IDX_W-1:0]  row_idx,    // row index 0..4
  input  wire logic [mc_pkg::COND_SEL_W-1:0] row_cond,   // condition selector
  input  wire logic [mc_pkg::PC_W-1:0]       row_dest,   // jump destination
  input  wire logic [mc_pkg::COND_N-1:0]     cond,       // live conditions
  input  wire logic [mc_pkg::WAIT_ROWS-1:0]  row_select, // enabled rows
  output logic                               hit,        // some row satisfied
  output logic [mc_pkg::PC_W-1:0]            hit_dest    // winning destination
);
  // ----------------------------------------------------------------
  // row storage
  // ----------------------------------------------------------------
  logic [mc_pkg::COND_SEL_W-1:0] cond_sel [mc_pkg::WAIT_ROWS]; // per-row condition
  logic [mc_pkg::PC_W-1:0]       dest     [mc_pkg::WAIT_ROWS]; // per-row destination
  logic [mc_pkg::WAIT_ROWS-1:0]  row_true;                     // row condition now true

  genvar g;
  generate
    for (g = 0; g < mc_pkg::WAIT_ROWS; g++) begin : g_row
      // each row keeps condition and destination until rewritten
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cond_sel[g] <= '0;
          dest[g]     <= '0;
        end else if (row_wr && int'(row_idx) == g) begin
          cond_sel[g] <= row_cond;
          dest[g]     <= row_dest;
        end
      end
      assign row_true[g] = cond[cond_sel[g]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // row select and priority
  // ----------------------------------------------------------------
  // scan downward so the lowest row is the last to overwrite
  always_comb begin
    hit      = 1'b0;
    hit_dest = '0;
    for (int i = mc_pkg::WAIT_ROWS - 1; i >= 0; i--) begin
      if (row_select[i] && row_true[i]) begin
        hit      = 1'b1;
        hit_dest = dest[i];
      end
    end
  end

  a_hit_enabled: assert property (@(posedge clk) disable iff (!nrst)
    hit |-> ((row_select & row_true) != '0))
    else $error("wait hit without an enabled satisfied row");

  a_lowest_wins: assert property (@(posedge clk) disable iff (!nrst)
    (row_select[0] && row_true[0]) |-> hit_dest == dest[0])
    else $error("row 1 did not take priority");
endmodule

`default_nettype wire
